//--- sac_device.sv
`default_nettype none
// Overview of operation
// - shift only while latch enable is low
// - sample data on each rising serial clock
// - host holds enable low for sixteen bits
// - address byte then code byte, msb first
// - nonzero address word is discarded entirely
// - enable rising edge latches and decodes word
// - power-up and reset give mute
// - codes 0 to 62 give that dB
// - codes 63 and above give mute
// - serial clock falls no later than enable
// - host steps one dB at a time
module sac_device (
  // system
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  // link, serial clock is this end's link domain
  sac_link_if.device                 link,
  // decoded setting
  output logic [5:0]                 atten_db_out,
  output logic                       mute_out,
  output logic                       update_out,
  output logic                       reject_out
);
  // link domain: shift register on the serial clock
  logic [sac_pkg::WORD_BITS-1:0] shift;
  logic [sac_pkg::WORD_BITS-1:0] next_shift;

  always_comb begin
    next_shift = shift;
    if (!link.load_n) begin
      next_shift = {shift[sac_pkg::WORD_BITS-2:0], link.sdata};
    end
  end

  always_ff @(posedge link.sclk or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shift <= '0;
    end else begin
      shift <= next_shift;
    end
  end

  // system domain: latch enable through two flops, then edge detect.
  // shift is frozen while enable is high, so sampling it after the
  // synchronised rise is a safe word crossing.
  logic load_s1;
  logic load_s2;
  logic load_s3;
  logic [5:0] level;
  logic       mute;
  logic       upd;
  logic       rej;
  logic [5:0] next_level;
  logic       next_mute;
  logic       next_upd;
  logic       next_rej;
  logic [7:0] addr_byte;
  logic [7:0] code_byte;

  assign addr_byte = shift[sac_pkg::ADDR_MSB:sac_pkg::ADDR_LSB];
  assign code_byte = shift[sac_pkg::CODE_MSB:sac_pkg::CODE_LSB];

  always_comb begin
    next_level = level;
    next_mute  = mute;
    next_upd   = 1'b0;
    next_rej   = 1'b0;
    if (load_s2 && !load_s3) begin
      if (addr_byte != sac_pkg::CHANNEL_ADDR) begin
        next_rej = 1'b1;
      end else begin
        next_upd = 1'b1;
        if (code_byte > sac_pkg::MAX_STEP_CODE) begin
          next_mute  = 1'b1;
          next_level = sac_pkg::RESET_LEVEL;
        end else begin
          next_mute  = 1'b0;
          next_level = code_byte[5:0];
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      load_s1 <= 1'b1;
      load_s2 <= 1'b1;
      load_s3 <= 1'b1;
      level   <= sac_pkg::RESET_LEVEL;
      mute    <= sac_pkg::RESET_MUTE;
      upd     <= 1'b0;
      rej     <= 1'b0;
    end else begin
      load_s1 <= link.load_n;
      load_s2 <= load_s1;
      load_s3 <= load_s2;
      level   <= next_level;
      mute    <= next_mute;
      upd     <= next_upd;
      rej     <= next_rej;
    end
  end

  assign atten_db_out = level;
  assign mute_out     = mute;
  assign update_out   = upd;
  assign reject_out   = rej;
endmodule
`default_nettype wire

//--- sac_host.sv
`default_nettype none
module sac_host #(
  parameter int unsigned HALF_CYC  = sac_pkg::SCLK_HALF_CYC,
  parameter int unsigned SETUP_CYC = sac_pkg::LOAD_SETUP_CYC,
  parameter int unsigned GAP_CYC   = sac_pkg::LOAD_GAP_CYC
) (
  // system
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  // user request
  input  wire logic                  target_valid_in,
  input  wire logic [7:0]            target_code_in,
  output logic                       busy_out,
  output logic [7:0]                 current_code_out,
  // link, serial clock made here by division
  sac_link_if.host                   link
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_LO    = 3'b010,
    ST_HI    = 3'b011,
    ST_TAIL  = 3'b100,
    ST_GAP   = 3'b101
  } sac_host_state_e;

  sac_host_state_e state;
  sac_host_state_e next_state;
  logic [sac_pkg::CNT_BITS-1:0]  cnt;
  logic [sac_pkg::CNT_BITS-1:0]  next_cnt;
  logic [4:0]                    bits;
  logic [4:0]                    next_bits;
  logic [sac_pkg::WORD_BITS-1:0] word;
  logic [sac_pkg::WORD_BITS-1:0] next_word;
  logic [7:0]                    cur;
  logic [7:0]                    next_cur;
  logic [7:0]                    tgt;
  logic [7:0]                    next_tgt;
  logic [7:0]                    step;
  logic [7:0]                    next_step;
  logic                          load_n;
  logic                          next_load_n;
  logic                          sclk;
  logic                          next_sclk;

  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_bits   = bits;
    next_word   = word;
    next_cur    = cur;
    next_tgt    = tgt;
    next_step   = step;
    next_load_n = load_n;
    next_sclk   = sclk;
    if (target_valid_in) begin
      // anything from mute upward folds onto the single mute code
      next_tgt = (target_code_in > sac_pkg::MUTE_CODE) ? sac_pkg::MUTE_CODE : target_code_in;
    end
    case (state)
      ST_IDLE: begin
        if (cur != tgt) begin
          // one dB per word, never a jump
          next_step   = (tgt > cur) ? cur + 8'h01 : cur - 8'h01;
          next_word   = {sac_pkg::CHANNEL_ADDR, next_step};
          next_load_n = 1'b0;
          next_cnt    = sac_pkg::CNT_BITS'(SETUP_CYC - 1);
          next_bits   = '0;
          next_state  = ST_SETUP;
        end
      end
      ST_SETUP: begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0) begin
          next_sclk  = 1'b1;
          next_cnt   = sac_pkg::CNT_BITS'(HALF_CYC - 1);
          next_state = ST_HI;
        end
      end
      ST_LO: begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0) begin
          next_sclk  = 1'b1;
          next_cnt   = sac_pkg::CNT_BITS'(HALF_CYC - 1);
          next_state = ST_HI;
        end
      end
      ST_HI: begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0) begin
          next_sclk = 1'b0;
          next_word = {word[sac_pkg::WORD_BITS-2:0], 1'b0};
          next_bits = bits + 1'b1;
          next_cnt  = sac_pkg::CNT_BITS'(HALF_CYC - 1);
          next_state = (bits == 5'(sac_pkg::WORD_BITS - 1)) ? ST_TAIL : ST_LO;
        end
      end
      ST_TAIL: begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0) begin
          next_load_n = 1'b1;
          next_cnt    = sac_pkg::CNT_BITS'(GAP_CYC - 1);
          next_state  = ST_GAP;
        end
      end
      ST_GAP: begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0) begin
          next_cur   = step;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state  = ST_IDLE;
        next_load_n = 1'b1;
        next_sclk   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state  <= ST_IDLE;
      cnt    <= '0;
      bits   <= '0;
      word   <= '0;
      cur    <= sac_pkg::MUTE_CODE;
      tgt    <= sac_pkg::MUTE_CODE;
      step   <= sac_pkg::MUTE_CODE;
      load_n <= 1'b1;
      sclk   <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      bits   <= next_bits;
      word   <= next_word;
      cur    <= next_cur;
      tgt    <= next_tgt;
      step   <= next_step;
      load_n <= next_load_n;
      sclk   <= next_sclk;
    end
  end

  assign link.load_n      = load_n;
  assign link.sclk        = sclk;
  assign link.sdata       = word[sac_pkg::WORD_BITS-1];
  assign busy_out         = (state != ST_IDLE) || (cur != tgt);
  assign current_code_out = cur;
endmodule
`default_nettype wire

//--- sac_link_if.sv
`default_nettype none
interface sac_link_if;
  logic load_n;
  logic sclk;
  logic sdata;
  modport host (
    output load_n,
    output sclk,
    output sdata
  );
  modport device (
    input  load_n,
    input  sclk,
    input  sdata
  );
endinterface
`default_nettype wire

//--- sac_link_sva.sv
`default_nettype none
module sac_link_sva (
  // system
  input wire logic clk_in,
  input wire logic arst_n_in,
  // link
  input wire logic load_n,
  input wire logic sclk,
  input wire logic sdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] n_rise;
  logic [4:0] next_n_rise;
  logic       sclk_q;
  // serial rises since the enable fell
  always_comb begin
    next_n_rise = n_rise;
    if (load_n) next_n_rise = 5'h00;
    else if (sclk && !sclk_q) next_n_rise = n_rise + 5'h01;
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      n_rise <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      n_rise <= next_n_rise;
      sclk_q <= sclk;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_open;
    $fell(load_n);
  endsequence
  sequence s_close;
    $rose(load_n);
  endsequence
  a_idle_clock_low: assert property (load_n |-> !sclk)
    else $error("serial clock high while idle");
  a_setup_time: assert property (s_open |-> !sclk [*6])
    else $error("serial clock rose too soon after enable");
  a_clock_first: assert property (s_open |-> !$past(sclk))
    else $error("serial clock fell after enable");
  a_high_time: assert property ($rose(sclk) |-> sclk [*8])
    else $error("serial clock high too short");
  a_data_steady: assert property (sclk && $past(sclk) |-> $stable(sdata))
    else $error("data moved while clock high");
  a_sixteen_bits: assert property (s_close |-> n_rise == 5'h10)
    else $error("word length not sixteen");
  a_address_zero: assert property ($rose(sclk) && n_rise < 5'h08 |-> !sdata)
    else $error("address bit not zero");
  a_word_gap: assert property (s_close |-> load_n [*4])
    else $error("gap between words too short");
endmodule
`default_nettype wire

//--- sac_pkg.sv
`default_nettype none
package sac_pkg;
  // word layout
  localparam int unsigned WORD_BITS     = 16;
  localparam int unsigned ADDR_BITS     = 8;
  localparam int unsigned CODE_BITS     = 8;
  localparam int unsigned ADDR_MSB      = 15;
  localparam int unsigned ADDR_LSB      = 8;
  localparam int unsigned CODE_MSB      = 7;
  localparam int unsigned CODE_LSB      = 0;
  localparam int unsigned LEVEL_BITS    = 6;
  // address and code values
  localparam logic [7:0]  CHANNEL_ADDR  = 8'h00;
  localparam logic [7:0]  MAX_STEP_CODE = 8'h3E;
  localparam logic [7:0]  MUTE_CODE     = 8'h3F;
  // reset values
  localparam logic [5:0]  RESET_LEVEL   = 6'h3F;
  localparam logic        RESET_MUTE    = 1'b1;
  // timing, host side
  localparam int unsigned CLK_PERIOD_NS    = 25;
  localparam int unsigned SCLK_PERIOD_NS   = 500;
  localparam int unsigned LOAD_SETUP_NS    = 150;
  localparam int unsigned LOAD_GAP_NS      = 500;
  localparam int unsigned SCLK_HALF_CYC    =
    ((SCLK_PERIOD_NS / 2) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOAD_SETUP_CYC   =
    (LOAD_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOAD_GAP_CYC     =
    (LOAD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_BITS         = 6;
endpackage
`default_nettype wire

//--- tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_in, arst_n_in, tgt_valid, busy, mute, mute_b, upd, upd_b, rej_b;
  logic [7:0] tgt_code, cur_code;
  logic [5:0] atten, atten_b;
  int         error_cnt = 0, n_checks = 0, n_upd = 0, n_upd_b = 0, n_rej_b = 0;
  sac_link_if link_if ();
  sac_link_if link_b ();
  sac_host sac_host_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .target_valid_in(tgt_valid),
    .target_code_in(tgt_code), .busy_out(busy), .current_code_out(cur_code), .link(link_if));
  sac_device sac_device_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(link_if),
    .atten_db_out(atten), .mute_out(mute), .update_out(upd), .reject_out());
  // second device faces the bench driver
  sac_device sac_device_inst_b (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(link_b),
    .atten_db_out(atten_b), .mute_out(mute_b), .update_out(upd_b), .reject_out(rej_b));
  sac_link_sva sac_link_sva_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .load_n(link_if.load_n), .sclk(link_if.sclk), .sdata(link_if.sdata));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (upd === 1'b1) n_upd++;
    if (upd_b === 1'b1) n_upd_b++;
    if (rej_b === 1'b1) n_rej_b++;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_goto(input logic [7:0] code, input int steps);
    int k;
    int s;
    logic m;
    s = n_upd;
    m = code > 8'h3E;
    tgt_valid <= 1'b1;
    tgt_code <= code;
    @(posedge clk_in);
    tgt_valid <= 1'b0;
    repeat (3) @(posedge clk_in);
    for (k = 0; busy !== 1'b0 && k < 30000; k++) @(posedge clk_in);
    if (k == 30000) begin
      error_cnt++;
      complete_run();
    end
    repeat (8) @(posedge clk_in);
    chk(cur_code, m ? 8'h3F : code);
    chk({2'h0, atten}, m ? 8'h3F : code);
    chk({7'h00, mute}, {7'h00, m});
    chk(8'(n_upd - s), 8'(steps));
    $display("test goto %h done", code);
  endtask
  // bench host on the second link, four stray serial clocks after each frame
  task automatic b_send(input logic [23:0] w, input int n, input logic [5:0] db,
                        input logic m, input logic rj);
    int u;
    int r;
    u = n_upd_b;
    r = n_rej_b;
    link_b.load_n <= 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      link_b.sdata <= w[i];
      #32 link_b.sclk <= 1'b1;
      #32 link_b.sclk <= 1'b0;
    end
    #32 link_b.load_n <= 1'b1;
    // stray edges while idle must not shift
    repeat (4) begin
      link_b.sdata <= ~link_b.sdata;
      #32 link_b.sclk <= 1'b1;
      #32 link_b.sclk <= 1'b0;
    end
    repeat (10) @(posedge clk_in);
    chk({2'h0, atten_b}, {2'h0, db});
    chk({7'h00, mute_b}, {7'h00, m});
    chk(8'(n_rej_b - r), {7'h00, rj});
    chk(8'(n_upd_b - u), {7'h00, !rj});
    $display("test word %h done", w);
  endtask
  task automatic t_reset;
    chk({2'h0, atten}, 8'h3F);
    chk({7'h00, mute_b}, 8'h01);
    chk(cur_code, 8'h3F);
    $display("test reset done");
  endtask
  task automatic t_codes;
    logic [7:0] c[5] = '{8'h3E, 8'h3F, 8'h40, 8'hFF, 8'h00};
    foreach (c[i]) b_send({16'h0000, c[i]}, 16, c[i] > 8'h3E ? 6'h3F : c[i][5:0],
                          c[i] > 8'h3E, 1'b0);
  endtask
  task automatic t_odd_len;
    b_send(24'h0F000C, 20, 6'h0C, 1'b0, 1'b0);
    b_send(24'h008000, 16, 6'h0C, 1'b0, 1'b1);
    b_send(24'h000009, 8, 6'h09, 1'b0, 1'b0);
  endtask
  initial begin
    arst_n_in <= 1'b0;
    tgt_valid <= 1'b0;
    tgt_code <= 8'h00;
    link_b.load_n <= 1'b1;
    link_b.sclk <= 1'b0;
    link_b.sdata <= 1'b0;
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    b_send(24'h000005, 16, 6'h05, 1'b0, 1'b0);
    b_send(24'h008107, 16, 6'h05, 1'b0, 1'b1);
    t_codes();
    t_odd_len();
    t_goto(8'h02, 61);
    t_goto(8'h00, 2);
    t_goto(8'hC0, 63);
    complete_run();
  end
endmodule
`default_nettype wire
